// file: rtl/secd_pkg.sv
// Purpose: shared constants and types of the seismic event coincidence detector
// Assumes: one clock; every time figure is counted in sample ticks
// Notes:   channel select 0 means the trigger slot is off
package secd_pkg;
  localparam int NTRIG     = 6;
  localparam int NCH       = 6;
  localparam int NENV      = 2;
  localparam int DW        = 16;
  localparam int FW        = 18;
  localparam int CW        = 3;
  localparam int KW        = 4;
  localparam int LW        = 16;
  localparam int TW        = 24;
  localparam int PAW       = 10;
  localparam int PRE_DEPTH = 1024;
  localparam int IW        = 3;
  localparam logic [CW-1:0] CHAN_OFF = 3'h0;
  localparam logic [TW-1:0] ONE_TICK = 24'h000001;

  typedef enum logic [1:0]
  {
    SECD_MSG_TRIG_ON  = 2'b00,
    SECD_MSG_TRIG_OFF = 2'b01,
    SECD_MSG_EV_ON    = 2'b10,
    SECD_MSG_EV_OFF   = 2'b11
  } secd_msg_t;

  typedef enum logic
  {
    SECD_TYPE_THRESH = 1'b0,
    SECD_TYPE_RATIO  = 1'b1
  } secd_ttype_t;

  typedef enum logic
  {
    SECD_MODE_CONT  = 1'b0,
    SECD_MODE_EVENT = 1'b1
  } secd_mode_t;

  typedef enum logic
  {
    SECD_EV_IDLE   = 1'b0,
    SECD_EV_ACTIVE = 1'b1
  } secd_ev_t;
endpackage : secd_pkg

// file: rtl/secd_detector.sv
// Purpose: trigger filtering, event coincidence, record gating, log messages
// Assumes: samples arrive on samp_valid in the clk domain, one tick per sample
// Notes:   durations and intervals are sample counts set by software
`timescale 1ns/1ps
`default_nettype none
module secd_detector
(
  input  wire logic                                     clk,
  input  wire logic                                     srst,
  input  wire logic                                     samp_valid,
  input  wire logic [secd_pkg::NCH*secd_pkg::DW-1:0]    samp_data,
  input  wire logic                                     rec_enable,
  input  wire logic                                     rec_mode,
  input  wire logic [secd_pkg::NTRIG*secd_pkg::CW-1:0]  trig_chan,
  input  wire logic [secd_pkg::NTRIG-1:0]               trig_type,
  input  wire logic [secd_pkg::NTRIG*secd_pkg::LW-1:0]  trig_level,
  input  wire logic [secd_pkg::NTRIG*secd_pkg::TW-1:0]  trig_report_dly,
  input  wire logic [secd_pkg::NTRIG*secd_pkg::TW-1:0]  trig_detrig,
  input  wire logic [secd_pkg::NTRIG*secd_pkg::KW-1:0]  trig_sta_k,
  input  wire logic [secd_pkg::NTRIG*secd_pkg::KW-1:0]  trig_lta_k,
  input  wire logic [secd_pkg::NTRIG*secd_pkg::CW-1:0]  trig_hp_order,
  input  wire logic [secd_pkg::NTRIG*secd_pkg::KW-1:0]  trig_hp_k,
  input  wire logic [secd_pkg::NTRIG*secd_pkg::CW-1:0]  trig_lp_order,
  input  wire logic [secd_pkg::NTRIG*secd_pkg::KW-1:0]  trig_lp_k,
  input  wire logic [secd_pkg::TW-1:0]                  coinc_window,
  input  wire logic [secd_pkg::IW-1:0]                  onset_count,
  input  wire logic [secd_pkg::IW-1:0]                  release_count,
  input  wire logic [secd_pkg::TW-1:0]                  max_duration,
  input  wire logic [secd_pkg::PAW-1:0]                 pre_event,
  input  wire logic [secd_pkg::TW-1:0]                  post_event,
  input  wire logic [secd_pkg::NENV*secd_pkg::IW-1:0]   env_sel,
  input  wire logic [secd_pkg::TW-1:0]                  env_interval,
  output logic                                          rec_valid,
  output logic [secd_pkg::NCH*secd_pkg::DW-1:0]         rec_data,
  output logic                                          event_active,
  output logic                                          msg_valid,
  output logic [1:0]                                    msg_type,
  output logic [secd_pkg::IW-1:0]                       msg_index,
  output logic                                          env_valid,
  output logic [secd_pkg::NENV*secd_pkg::FW-1:0]        env_min,
  output logic [secd_pkg::NENV*secd_pkg::FW-1:0]        env_max
);
  localparam int NT = secd_pkg::NTRIG;
  localparam int FW = secd_pkg::FW;
  localparam int TW = secd_pkg::TW;

  logic [NT*FW-1:0] filt_all;
  logic [NT-1:0]    trig_now;
  logic [NT-1:0]    recent;
  logic [NT-1:0]    on_pend;
  logic [NT-1:0]    off_pend;
  logic [NT-1:0]    grant_on;
  logic [NT-1:0]    grant_off;
  logic             ev_on_pend_reg;
  logic             ev_off_pend_reg;
  logic             grant_ev_on;
  logic             grant_ev_off;

  // ---------------------------------------------------------------
  // trigger slots
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NT; i++)
  begin : g_trig
    logic [secd_pkg::CW-1:0] csel;
    logic                    enabled;
    logic signed [FW-1:0]    x;
    logic signed [FW-1:0]    hp;
    logic signed [FW-1:0]    y;
    logic signed [FW-1:0]    amp;
    logic signed [FW-1:0]    hp_st_reg;
    logic signed [FW-1:0]    lp_st_reg;
    logic signed [FW-1:0]    sta_reg;
    logic signed [FW-1:0]    lta_reg;
    logic [FW+secd_pkg::LW-1:0] lta_mult;
    logic                    trig_reg;
    logic                    reported_reg;
    logic                    on_pend_reg;
    logic                    off_pend_reg;
    logic [TW-1:0]           below_reg;
    logic [TW-1:0]           rpt_reg;
    logic [TW-1:0]           age_reg;
    logic                    turn_on;
    logic                    turn_off;

    assign csel    = trig_chan[i*secd_pkg::CW +: secd_pkg::CW];
    assign enabled = (csel != secd_pkg::CHAN_OFF) && (csel <= 3'(secd_pkg::NCH));

    always_comb
    begin
      x = '0;
      for (int c = 0; c < secd_pkg::NCH; c++)
        if (csel == 3'(c + 1))
          x = FW'($signed(samp_data[c*secd_pkg::DW +: secd_pkg::DW]));
      hp = (trig_hp_order[i*secd_pkg::CW +: secd_pkg::CW] == '0) ? x : x - hp_st_reg;
      y  = (trig_lp_order[i*secd_pkg::CW +: secd_pkg::CW] == '0) ? hp : lp_st_reg;
      amp = y[FW-1] ? -y : y;
      lta_mult = (FW+secd_pkg::LW)'(lta_reg) * trig_level[i*secd_pkg::LW +: secd_pkg::LW];
      if (trig_type[i] == secd_pkg::SECD_TYPE_RATIO)
      begin
        turn_on  = (FW+secd_pkg::LW)'(sta_reg) > lta_mult;
        turn_off = sta_reg <= lta_reg;
      end
      else
      begin
        turn_on  = amp > FW'(trig_level[i*secd_pkg::LW +: secd_pkg::LW]);
        turn_off = below_reg + secd_pkg::ONE_TICK >= trig_detrig[i*TW +: TW];
      end
    end

    // one-pole sections and short/long averages
    always_ff @(posedge clk)
    begin
      if (srst || !enabled)
      begin
        hp_st_reg <= '0;
        lp_st_reg <= '0;
        sta_reg   <= '0;
        lta_reg   <= '0;
      end
      else if (samp_valid)
      begin
        hp_st_reg <= hp_st_reg + ((x - hp_st_reg) >>> trig_hp_k[i*secd_pkg::KW +: secd_pkg::KW]);
        lp_st_reg <= lp_st_reg + ((hp - lp_st_reg) >>> trig_lp_k[i*secd_pkg::KW +: secd_pkg::KW]);
        sta_reg   <= sta_reg + ((amp - sta_reg) >>> trig_sta_k[i*secd_pkg::KW +: secd_pkg::KW]);
        lta_reg   <= lta_reg + ((amp - lta_reg) >>> trig_lta_k[i*secd_pkg::KW +: secd_pkg::KW]);
      end
    end

    // trigger state, detrigger timing, coincidence age
    always_ff @(posedge clk)
    begin
      if (srst || !enabled)
      begin
        trig_reg  <= 1'b0;
        below_reg <= '0;
        age_reg   <= '0;
      end
      else if (samp_valid)
      begin
        if (!trig_reg && turn_on)
        begin
          trig_reg <= 1'b1;
          age_reg  <= '0;
        end
        else if (age_reg != '1)
          age_reg <= age_reg + secd_pkg::ONE_TICK;
        if (trig_type[i] == secd_pkg::SECD_TYPE_THRESH && turn_on)
          below_reg <= '0;
        else if (trig_reg && turn_off)
        begin
          trig_reg  <= 1'b0;
          below_reg <= '0;
        end
        else if (trig_reg)
          below_reg <= below_reg + secd_pkg::ONE_TICK;
      end
    end

    // report delay and pending log messages; a new post beats a grant
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        rpt_reg      <= '0;
        reported_reg <= 1'b0;
        on_pend_reg  <= 1'b0;
        off_pend_reg <= 1'b0;
      end
      else
      begin
        if (grant_on[i])
          on_pend_reg <= 1'b0;
        if (grant_off[i])
          off_pend_reg <= 1'b0;
        if (!trig_reg)
        begin
          rpt_reg      <= '0;
          reported_reg <= 1'b0;
          if (reported_reg)
            off_pend_reg <= 1'b1;
        end
        else if (samp_valid && !reported_reg)
        begin
          if (rpt_reg >= trig_report_dly[i*TW +: TW])
          begin
            reported_reg <= 1'b1;
            on_pend_reg  <= 1'b1;
          end
          else
            rpt_reg <= rpt_reg + secd_pkg::ONE_TICK;
        end
      end
    end

    assign trig_now[i]             = trig_reg;
    assign recent[i]               = trig_reg && (age_reg < coinc_window);
    assign on_pend[i]              = on_pend_reg;
    assign off_pend[i]             = off_pend_reg;
    assign filt_all[i*FW +: FW]    = y;
  end

  // ---------------------------------------------------------------
  // coincidence and event state
  // ---------------------------------------------------------------
  logic [secd_pkg::IW-1:0] recent_cnt;
  logic [secd_pkg::IW-1:0] active_cnt;
  secd_pkg::secd_ev_t      ev_state_reg;
  logic [TW-1:0]           dur_reg;

  always_comb
  begin
    recent_cnt = '0;
    active_cnt = '0;
    for (int t = 0; t < NT; t++)
    begin
      recent_cnt = recent_cnt + secd_pkg::IW'(recent[t]);
      active_cnt = active_cnt + secd_pkg::IW'(trig_now[t]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ev_state_reg    <= secd_pkg::SECD_EV_IDLE;
      dur_reg         <= '0;
      ev_on_pend_reg  <= 1'b0;
      ev_off_pend_reg <= 1'b0;
    end
    else
    begin
      if (grant_ev_on)
        ev_on_pend_reg <= 1'b0;
      if (grant_ev_off)
        ev_off_pend_reg <= 1'b0;
      if (samp_valid)
      begin
        unique case (ev_state_reg)
          secd_pkg::SECD_EV_IDLE:
            if (onset_count != '0 && recent_cnt >= onset_count)
            begin
              ev_state_reg   <= secd_pkg::SECD_EV_ACTIVE;
              dur_reg        <= '0;
              ev_on_pend_reg <= 1'b1;
            end
          secd_pkg::SECD_EV_ACTIVE:
            if (active_cnt < release_count
                || dur_reg + secd_pkg::ONE_TICK >= max_duration)
            begin
              ev_state_reg    <= secd_pkg::SECD_EV_IDLE;
              ev_off_pend_reg <= 1'b1;
            end
            else
              dur_reg <= dur_reg + secd_pkg::ONE_TICK;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // log message arbiter: event messages first, then lowest slot
  // ---------------------------------------------------------------
  always_comb
  begin
    grant_ev_on  = ev_on_pend_reg;
    grant_ev_off = !ev_on_pend_reg && ev_off_pend_reg;
    grant_on     = '0;
    grant_off    = '0;
    for (int t = NT - 1; t >= 0; t--)
      if (!ev_on_pend_reg && !ev_off_pend_reg && (on_pend[t] || off_pend[t]))
      begin
        grant_on  = '0;
        grant_off = '0;
        if (on_pend[t])
          grant_on[t] = 1'b1;
        else
          grant_off[t] = 1'b1;
      end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      msg_valid <= 1'b0;
      msg_type  <= '0;
      msg_index <= '0;
    end
    else
    begin
      msg_valid <= grant_ev_on || grant_ev_off || (grant_on != '0) || (grant_off != '0);
      msg_index <= '0;
      if (grant_ev_on)
        msg_type <= secd_pkg::SECD_MSG_EV_ON;
      else if (grant_ev_off)
        msg_type <= secd_pkg::SECD_MSG_EV_OFF;
      else
        msg_type <= (grant_on != '0) ? secd_pkg::SECD_MSG_TRIG_ON : secd_pkg::SECD_MSG_TRIG_OFF;
      for (int t = 0; t < NT; t++)
        if (grant_on[t] || grant_off[t])
          msg_index <= secd_pkg::IW'(t);
    end
  end

  // ---------------------------------------------------------------
  // pre-event delay line and record gate
  // ---------------------------------------------------------------
  logic [secd_pkg::NCH*secd_pkg::DW-1:0] pre_mem [secd_pkg::PRE_DEPTH];
  logic [secd_pkg::PAW-1:0]              wptr_reg;
  logic [TW-1:0]                         tail_reg;
  logic [secd_pkg::NCH*secd_pkg::DW-1:0] delayed;
  logic                                  gate;

  assign delayed = (pre_event == '0) ? samp_data : pre_mem[wptr_reg - pre_event];
  assign gate    = (ev_state_reg == secd_pkg::SECD_EV_ACTIVE) || (tail_reg != '0);

  always_ff @(posedge clk)
  begin
    if (samp_valid)
      pre_mem[wptr_reg] <= samp_data;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wptr_reg <= '0;
      tail_reg <= '0;
    end
    else if (samp_valid)
    begin
      wptr_reg <= wptr_reg + 1'b1;
      if (ev_state_reg == secd_pkg::SECD_EV_ACTIVE)
        tail_reg <= post_event + TW'(pre_event);
      else if (tail_reg != '0)
        tail_reg <= tail_reg - secd_pkg::ONE_TICK;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rec_valid    <= 1'b0;
      rec_data     <= '0;
      event_active <= 1'b0;
    end
    else
    begin
      event_active <= (ev_state_reg == secd_pkg::SECD_EV_ACTIVE);
      rec_valid    <= 1'b0;
      if (samp_valid && rec_enable)
      begin
        if (rec_mode == secd_pkg::SECD_MODE_CONT)
        begin
          rec_valid <= 1'b1;
          rec_data  <= samp_data;
        end
        else
        begin
          rec_valid <= gate;
          rec_data  <= delayed;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // envelope preview channels
  // ---------------------------------------------------------------
  logic [TW-1:0] ivl_reg;
  logic          ivl_end;

  assign ivl_end = samp_valid && (ivl_reg + secd_pkg::ONE_TICK >= env_interval);

  always_ff @(posedge clk)
  begin
    if (srst)
      ivl_reg <= '0;
    else if (ivl_end)
      ivl_reg <= '0;
    else if (samp_valid)
      ivl_reg <= ivl_reg + secd_pkg::ONE_TICK;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      env_valid <= 1'b0;
    else
      env_valid <= ivl_end;
  end

  for (genvar e = 0; e < secd_pkg::NENV; e++)
  begin : g_env
    logic signed [FW-1:0]    v;
    logic signed [FW-1:0]    lo_reg;
    logic signed [FW-1:0]    hi_reg;
    logic                    first_reg;
    logic [secd_pkg::IW-1:0] s;

    assign s = env_sel[e*secd_pkg::IW +: secd_pkg::IW];
    assign v = (s < secd_pkg::IW'(NT)) ? filt_all[s*FW +: FW] : '0;

    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        lo_reg    <= '0;
        hi_reg    <= '0;
        first_reg <= 1'b1;
        env_min[e*FW +: FW] <= '0;
        env_max[e*FW +: FW] <= '0;
      end
      else if (samp_valid)
      begin
        if (ivl_end)
        begin
          env_min[e*FW +: FW] <= (first_reg || v < lo_reg) ? v : lo_reg;
          env_max[e*FW +: FW] <= (first_reg || v > hi_reg) ? v : hi_reg;
          first_reg <= 1'b1;
        end
        else
        begin
          lo_reg    <= (first_reg || v < lo_reg) ? v : lo_reg;
          hi_reg    <= (first_reg || v > hi_reg) ? v : hi_reg;
          first_reg <= 1'b0;
        end
      end
    end
  end
endmodule : secd_detector
`default_nettype wire

// file: sim/secd_props.sv
// Purpose: port checks of the event coincidence detector
// Assumes: one clock domain, srst synchronous
// Notes:   bound to every secd_detector below
`timescale 1ns/1ps
`default_nettype none
module secd_props
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        samp_valid,
  input wire logic [95:0] samp_data,
  input wire logic        rec_enable,
  input wire logic        rec_mode,
  input wire logic [2:0]  onset_count,
  input wire logic [9:0]  pre_event,
  input wire logic        rec_valid,
  input wire logic [95:0] rec_data,
  input wire logic        event_active,
  input wire logic        msg_valid,
  input wire logic [1:0]  msg_type,
  input wire logic [2:0]  msg_index,
  input wire logic        env_valid,
  input wire logic [35:0] env_min,
  input wire logic [35:0] env_max
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ---
  // checks
  // ---
  chk_rec_after_tick:
    assert property (rec_valid |-> $past(samp_valid))
    else $error("record strobe without a sample tick");
  chk_rec_needs_en:
    assert property (rec_valid |-> $past(rec_enable))
    else $error("record strobe while recording stopped");
  chk_cont_every:
    assert property (samp_valid && rec_enable && !rec_mode |=> rec_valid)
    else $error("continuous sample not recorded");
  chk_cont_data:
    assert property (rec_valid && !$past(rec_mode) && pre_event == 10'h000
                     |-> rec_data == $past(samp_data))
    else $error("continuous record data differs from sample");
  chk_event_on_msg:
    assert property ($rose(event_active) |-> msg_valid && msg_type == 2'h2)
    else $error("event start message missing");
  chk_event_off_msg:
    assert property ($fell(event_active) |-> msg_valid && msg_type == 2'h3)
    else $error("event end message missing");
  chk_event_msg_idx:
    assert property (msg_valid && msg_type[1] |-> msg_index == 3'h0)
    else $error("event message with nonzero index");
  chk_env_order:
    assert property (env_valid |-> $signed(env_min[17:0]) <= $signed(env_max[17:0])
                     && $signed(env_min[35:18]) <= $signed(env_max[35:18]))
    else $error("envelope minimum above maximum");
  chk_onset_zero:
    assert property ($rose(event_active) |-> $past(onset_count, 2) != 3'h0)
    else $error("event declared with detection disabled");
  chk_slot_range:
    assert property (msg_valid && !msg_type[1] |-> msg_index <= 3'h5)
    else $error("trigger message from a slot beyond six");
  cov_event_on: cover property ($rose(event_active));
  cov_event_off: cover property ($fell(event_active));
  cov_env: cover property (env_valid);
  cov_cont: cover property (rec_valid && !rec_mode);
endmodule : secd_props

bind secd_detector secd_props u_props (.clk, .srst, .samp_valid, .samp_data, .rec_enable,
  .rec_mode, .onset_count, .pre_event, .rec_valid, .rec_data, .event_active, .msg_valid,
  .msg_type, .msg_index, .env_valid, .env_min, .env_max);
`default_nettype wire

// file: sim/secd_src.sv
// Purpose: paced sample source feeding the detector, data passed through unfiltered
// Assumes: one sample every other clock while run is high
// Notes:   data lines carry inverted junk between samples
`timescale 1ns/1ps
`default_nettype none
module secd_src
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        run,
  input  wire logic [95:0] val,
  output logic             samp_valid,
  output logic [95:0]      samp_data
);
  // ---
  // sample ticks
  // ---
  initial
  begin
    samp_valid = 1'b0;
    samp_data  = 96'h0;
  end
  always @(posedge clk)
  begin
    if (srst || !run || samp_valid)
    begin
      samp_valid <= 1'b0;
      samp_data  <= ~val;
    end
    else
    begin
      samp_valid <= 1'b1;
      samp_data  <= val;
    end
  end
endmodule : secd_src
`default_nettype wire

// file: sim/seismic_event_coincidence_detector_bench.sv
// Purpose: self-checking bench for the event coincidence detector
// Assumes: 200 MHz clock, inputs driven on the falling edge
// Notes:   durations kept small, all in samples
`timescale 1ns/1ps
`default_nettype none
module seismic_event_coincidence_detector_bench;
  logic         clk, srst, run, samp_valid, rec_enable, rec_mode;
  logic         rec_valid, event_active, msg_valid, env_valid;
  logic [95:0]  val, samp_data, rec_data, tlevel;
  logic [17:0]  tchan, tord;
  logic [5:0]   ttype, env_sel;
  logic [143:0] tdly, tdet;
  logic [23:0]  tk, tlk, coinc_window, max_duration, post_event, env_interval;
  logic [2:0]   onset_count, release_count, msg_index;
  logic [9:0]   pre_event;
  logic [1:0]   msg_type;
  logic [35:0]  env_min, env_max;
  int           miscompares, checked;

  secd_src src (.clk, .srst, .run, .val, .samp_valid, .samp_data);
  secd_detector DUT (.clk, .srst, .samp_valid, .samp_data, .rec_enable, .rec_mode,
    .trig_chan(tchan), .trig_type(ttype), .trig_level(tlevel), .trig_report_dly(tdly),
    .trig_detrig(tdet), .trig_sta_k(tk), .trig_lta_k(tlk), .trig_hp_order(tord),
    .trig_hp_k(tk), .trig_lp_order(tord), .trig_lp_k(tk), .coinc_window, .onset_count,
    .release_count, .max_duration, .pre_event, .post_event, .env_sel, .env_interval,
    .rec_valid, .rec_data, .event_active, .msg_valid, .msg_type, .msg_index,
    .env_valid, .env_min, .env_max);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ---
  // helpers
  // ---
  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic sig(input int w);
    case (w)
      0: return event_active;
      1: return rec_valid;
      2: return env_valid;
      default: return msg_valid && msg_index == 3'h2;
    endcase
  endfunction : sig

  task automatic wait_for(input int w, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(posedge clk);
      #1;
      if (sig(w) === lvl)
        break;
    end
    chk({95'h0, sig(w)}, {95'h0, lvl});
    if (i == lim)
      report_and_stop();
  endtask : wait_for

  task automatic quiet(input int w, input int n);
    int hits;
    hits = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (sig(w) !== 1'b0)
        hits++;
    end
    chk(96'(hits), 96'h0);
  endtask : quiet

  task automatic slot(input int s, input logic [2:0] ch, input logic [15:0] lvl);
    tchan[s*3+:3] = ch;
    tlevel[s*16+:16] = lvl;
  endtask : slot
  // ---
  // scenarios
  // ---
  task automatic t_cont;
    @(negedge clk);
    val = 96'h0006_0005_0004_0003_0002_0001;
    rec_mode = 1'b0;
    repeat (3) @(negedge clk);
    rec_enable = 1'b1;
    wait_for(1, 1'b1, 20);
    chk(rec_data, val);
    @(negedge clk);
    rec_enable = 1'b0;
    quiet(1, 20);
  endtask : t_cont

  task automatic t_idle;
    @(negedge clk);
    rec_mode = 1'b1;
    rec_enable = 1'b1;
    quiet(1, 40);
  endtask : t_idle

  task automatic t_event;
    @(negedge clk);
    slot(0, 3'h1, 16'h0064);
    slot(1, 3'h2, 16'h0064);
    pre_event = 10'h003;
    post_event = 24'h000004;
    val = {64'h0, 16'h03e8, 16'h03e8};
    wait_for(0, 1'b1, 200);
    wait_for(1, 1'b1, 20);
    chk(rec_data, 96'h0006_0005_0004_0003_0002_0001);
    @(negedge clk);
    val = 96'h0;
    wait_for(0, 1'b0, 300);
    repeat (40) @(posedge clk);
    quiet(1, 40);
  endtask : t_event

  task automatic t_onset;
    @(negedge clk);
    onset_count = 3'h3;
    slot(2, 3'h0, 16'h0064);
    val = {48'h0, 16'h03e8, 16'h03e8, 16'h03e8};
    quiet(3, 60);
    quiet(0, 60);
    @(negedge clk);
    val = 96'h0;
    repeat (40) @(negedge clk);
    onset_count = 3'h2;
  endtask : t_onset

  task automatic t_maxdur;
    @(negedge clk);
    max_duration = 24'h000014;
    val = {64'h0, 16'h03e8, 16'h03e8};
    wait_for(0, 1'b1, 200);
    wait_for(0, 1'b0, 80);
    @(negedge clk);
    val = 96'h0;
    repeat (40) @(negedge clk);
    max_duration = 24'h0003e8;
  endtask : t_maxdur

  task automatic t_env;
    @(negedge clk);
    val = {64'h0, 16'hffce, 16'h012c};
    repeat (3) wait_for(2, 1'b1, 40);
    chk({60'h0, env_min}, {60'h0, 18'h3ffce, 18'h0012c});
    chk({60'h0, env_max}, {60'h0, 18'h3ffce, 18'h0012c});
  endtask : t_env

  task automatic t_ratio;
    @(negedge clk);
    ttype[2] = 1'b1;
    tlk[8+:4] = 4'h4;
    slot(2, 3'h3, 16'h0002);
    val = {48'h0, 16'h03e8, 32'h0};
    wait_for(3, 1'b1, 60);
    chk({94'h0, msg_type}, 96'h0);
    @(negedge clk);
    val = 96'h0;
    wait_for(3, 1'b1, 60);
    chk({94'h0, msg_type}, 96'h1);
  endtask : t_ratio

  initial
  begin
    miscompares = 0;
    checked = 0;
    srst = 1'b1;
    run = 1'b0;
    val = 96'h0;
    rec_enable = 1'b0;
    rec_mode = 1'b0;
    tchan = 18'h0;
    ttype = 6'h0;
    tlevel = {6{16'h7fff}};
    tord = 18'h0;
    tdly = {6{24'h000001}};
    tdet = {6{24'h000004}};
    tk = 24'h0;
    tlk = 24'h0;
    coinc_window = 24'h000032;
    onset_count = 3'h2;
    release_count = 3'h1;
    max_duration = 24'h0003e8;
    pre_event = 10'h000;
    post_event = 24'h000000;
    env_sel = 6'h08;
    env_interval = 24'h000008;
    repeat (12) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    run = 1'b1;
    t_cont();
    t_idle();
    t_event();
    t_onset();
    t_maxdur();
    t_env();
    t_ratio();
    report_and_stop();
  end
endmodule : seismic_event_coincidence_detector_bench
`default_nettype wire
